// ==== bench/pulse_source.sv ====
// Purpose: model of the pulse source on the accumulator input pin
// Assumes: pulse widths are whole clk_sys cycles
// Notes:   pin rests at idle_level outside bursts
`timescale 1ns/1ps
module pulse_source (
    input  wire logic clk_sys,
    input  wire logic idle_level,
    output logic      accum_input_pin
);
    initial accum_input_pin = 1'b0;

    always @(idle_level) accum_input_pin <= idle_level;

    // ----------------------------------------
    // burst of n pulses away from idle level
    // ----------------------------------------
    task automatic burst(input int n, input int width);
        repeat (n)
        begin
            @(posedge clk_sys);
            accum_input_pin <= ~idle_level;
            repeat (width) @(posedge clk_sys);
            accum_input_pin <= idle_level;
            repeat (width) @(posedge clk_sys);
        end
    endtask
endmodule

// ==== bench/test_timer_flags_pulse_accumulator.sv ====
// Purpose: self-checking bench for timer flags and pulse accumulator
// Assumes: design at clk_sys 50 MHz, synchronous active-high reset
// Notes:   periodic check uses rate code 00 only to bound run time
`timescale 1ns/1ps
module test_timer_flags_pulse_accumulator;
    import tmr_pkg::*;
    logic             clk_sys;
    logic             rst;
    logic [15:0]      reg_addr;
    logic [7:0]       reg_wdata;
    logic             reg_wr;
    logic             reg_rd;
    logic [7:0]       reg_rdata;
    logic             test_mode;
    logic [3:0]       cap_pin;
    logic             accum_input_pin;
    logic             idle_level;
    logic [4:0][15:0] cmp_value;
    logic [15:0]      free_running_count;
    logic [7:0]       irq_req_one;
    logic [7:0]       irq_req_two;
    logic [3:0]       capture_event;
    logic [15:0]      f0;
    time              t0;
    time              t1;
    int               n_tests = 0;
    int               err_total = 0;
    int               n_cap = 0;
    logic [15:0]      rst_addr [8] = '{16'h1020, OFS_EDGE_CTRL, OFS_EN_ONE, OFS_FLG_ONE,
                                       OFS_FLG_TWO, OFS_ACC_CTRL, OFS_ACC_CNT, 16'h1028};
    logic [15:0]      rw_addr [4] = '{OFS_EN_ONE, OFS_ACC_CTRL, OFS_EDGE_CTRL, OFS_ACC_CNT};
    logic [7:0]       ev_ctrl [3] = '{8'h50, 8'h40, 8'h10};
    logic [7:0]       ev_pre [3]  = '{8'hFE, 8'h00, 8'h00};
    logic [7:0]       ev_cnt [3]  = '{8'h01, 8'h03, 8'h00};
    logic [7:0]       ev_flg [3]  = '{8'h30, 8'h10, 8'h00};

    timer_flags_pulse_accumulator dut (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .test_mode(test_mode),
        .cap_pin(cap_pin), .accum_input_pin(accum_input_pin), .cmp_value(cmp_value),
        .free_running_count(free_running_count), .irq_req_one(irq_req_one),
        .irq_req_two(irq_req_two), .capture_event(capture_event)
    );

    pulse_source src (
        .clk_sys(clk_sys), .idle_level(idle_level), .accum_input_pin(accum_input_pin)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // counts channel one capture pulses
    always @(posedge clk_sys)
        if (capture_event[0] === 1'b1)
            n_cap <= n_cap + 1;

    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e, input string name);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(name, {8'h00, reg_rdata & m}, {8'h00, e});
    endtask

    task automatic wait_irq(input int b, output time t);
        int k;
        k = 0;
        while (irq_req_two[b] !== 1'b1 && k < 70000)
        begin
            @(posedge clk_sys);
            k++;
        end
        t = $time;
    endtask

    task automatic wait_cnt(input logic [15:0] v);
        int k;
        k = 0;
        while (free_running_count !== v && k < 70000)
        begin
            @(posedge clk_sys);
            k++;
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        cyc(95000);
        err_total++;
        summarize();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        test_mode = 1'b0;
        cap_pin = 4'h0;
        idle_level = 1'b0;
        cmp_value = {5{16'hFFFF}};
        cyc(4);
        rst <= 1'b0;
        wr(OFS_EN_TWO, 8'h01);
        wr(OFS_EN_TWO, 8'h02);
        rchk(OFS_EN_TWO, 8'hFF, 8'h01, "prescale once");
        for (int i = 0; i < 8; i++)
            rchk(rst_addr[i], 8'hFF, 8'h00, "reset value");
        f0 = free_running_count;
        cyc(40);
        #1 chk("count div4", free_running_count - f0, 16'd10);
        @(posedge clk_sys);
        test_mode <= 1'b1;
        wr(OFS_EN_TWO, 8'h03);
        test_mode <= 1'b0;
        cyc(1);
        #1 f0 = free_running_count;
        cyc(48);
        #1 chk("count div16", free_running_count - f0, 16'd3);
        @(posedge clk_sys);
        test_mode <= 1'b1;
        // let the divide-by-sixteen check window close first
        cyc(8);
        wr(OFS_EN_TWO, 8'hF0);
        rchk(OFS_EN_TWO, 8'hFF, 8'hF0, "mask two");
        f0 = free_running_count;
        cyc(40);
        #1 chk("count div1", free_running_count - f0, 16'd40);
        @(posedge clk_sys);
        test_mode <= 1'b0;
        wr(OFS_EN_TWO, 8'h03);
        rchk(OFS_EN_TWO, 8'h0F, 8'h00, "prescale late");
        wr(16'h1028, 8'hFF);
        rchk(16'h1028, 8'hFF, 8'h00, "unmapped");
        for (int i = 0; i < 4; i++)
        begin
            wr(rw_addr[i], 8'h5A);
            rchk(rw_addr[i], 8'hFF, 8'h5A, "rw reg");
            wr(rw_addr[i], 8'h00);
        end
        for (int s = 0; s < 2; s++)
        begin
            wr(OFS_ACC_CTRL, 8'(s << 2));
            wr(OFS_FLG_ONE, 8'hFF);
            @(posedge clk_sys);
            cmp_value <= {5{free_running_count + 16'd30}};
            cyc(40);
            rchk(OFS_FLG_ONE, 8'hFF, s ? 8'hF0 : 8'hF8, "compare flags");
        end
        wr(OFS_FLG_ONE, 8'h00);
        rchk(OFS_FLG_ONE, 8'hFF, 8'hF0, "write zero");
        wr(OFS_EN_ONE, 8'h10);
        cyc(2);
        #1 chk("irq one", {8'h00, irq_req_one}, 16'h0010);
        wr(OFS_FLG_ONE, 8'h10);
        cyc(2);
        #1 chk("irq one off", {8'h00, irq_req_one}, 16'h0000);
        rchk(OFS_FLG_ONE, 8'hFF, 8'hE0, "write one");
        wr(OFS_EN_ONE, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            wr(OFS_EDGE_CTRL, 8'(c << 4));
            wr(OFS_FLG_ONE, 8'hFF);
            @(posedge clk_sys);
            cap_pin[0] <= 1'b1;
            cyc(10);
            rchk(OFS_FLG_ONE, 8'h04, c[0] ? 8'h04 : 8'h00, "capture rise");
            wr(OFS_FLG_ONE, 8'hFF);
            @(posedge clk_sys);
            cap_pin[0] <= 1'b0;
            cyc(10);
            rchk(OFS_FLG_ONE, 8'h04, c[1] ? 8'h04 : 8'h00, "capture fall");
        end
        // channels two, three and four on rising edges, channel one off
        wr(OFS_EDGE_CTRL, 8'h45);
        wr(OFS_FLG_ONE, 8'hFF);
        @(posedge clk_sys);
        cap_pin <= 4'hF;
        cyc(10);
        rchk(OFS_FLG_ONE, 8'h0F, 8'h0B, "capture four");
        chk("capture pulses", 16'(n_cap), 16'd4);
        for (int i = 0; i < 3; i++)
        begin
            wr(OFS_ACC_CTRL, ev_ctrl[i]);
            wr(OFS_ACC_CNT, ev_pre[i]);
            wr(OFS_FLG_TWO, 8'hFF);
            src.burst(3, 6);
            cyc(8);
            rchk(OFS_ACC_CNT, 8'hFF, ev_cnt[i], "event count");
            rchk(OFS_FLG_TWO, 8'h30, ev_flg[i], "accum flags");
        end
        for (int g = 0; g < 2; g++)
        begin
            @(posedge clk_sys);
            idle_level <= g[0];
            cyc(8);
            wr(OFS_ACC_CTRL, 8'h60 | 8'(g << 4));
            wr(OFS_ACC_CNT, 8'h00);
            src.burst(1, 320);
            cyc(8);
            rchk(OFS_ACC_CNT, 8'hFF, 8'h05, "gated count");
        end
        wr(OFS_ACC_CTRL, 8'h00);
        wr(OFS_EN_TWO, 8'hC0);
        wr(OFS_FLG_TWO, 8'hFF);
        cyc(3);
        wait_irq(6, t0);
        wr(OFS_FLG_TWO, 8'h40);
        cyc(3);
        wait_irq(6, t1);
        chk("tick period", 16'((t1 - t0) / 20), 16'd8192);
        wr(OFS_FLG_TWO, 8'hFF);
        wait_cnt(16'hFFF0);
        rchk(OFS_FLG_TWO, 8'h80, 8'h00, "before wrap");
        wait_cnt(16'h0010);
        rchk(OFS_FLG_TWO, 8'h80, 8'h80, "after wrap");
        #1 chk("irq wrap", {15'h0000, irq_req_two[7]}, 16'h0001);
        summarize();
    end
endmodule

// ==== src/pin_sync.sv ====
// Purpose: three-stage pin synchroniser with edge pulses
// Assumes: pins are asynchronous to clk_sys
// Notes:   level changes only once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 5
)(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_d;
    logic [W-1:0] rise_d;
    logic [W-1:0] fall_d;

    always_comb
    begin
        lvl_d  = (s3_q & ~(s2_q ^ s3_q)) | (level & (s2_q ^ s3_q));
        rise_d = lvl_d & ~level;
        fall_d = ~lvl_d & level;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            level <= '0;
            rise  <= '0;
            fall  <= '0;
        end
        else
        begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            level <= lvl_d;
            rise  <= rise_d;
            fall  <= fall_d;
        end
    end
endmodule

// ==== src/tick_divider.sv ====
// Purpose: free-running divider giving prescale, periodic and gate enables
// Assumes: divider width covers the longest periodic shift
// Notes:   enables fire when the low bits of the divider are all ones
`timescale 1ns/1ps
module tick_divider
    import tmr_pkg::*;
#(
    parameter int DIV_W = 16
)(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [1:0] presc_sel,
    input  wire logic [1:0] rate_sel,
    tick_if.source          ticks
);
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;

    function automatic logic [DIV_W-1:0] low_ones(input int n);
        logic [DIV_W:0] m;
        m = ((DIV_W+1)'(1) << n) - (DIV_W+1)'(1);
        return m[DIV_W-1:0];
    endfunction

    always_comb
    begin
        div_d               = div_q + DIV_W'(1);
        ticks.count_tick    = &(div_q | ~low_ones(PRESC_SHIFT[presc_sel]));
        ticks.periodic_tick = &(div_q | ~low_ones(RATE_SHIFT_BASE + int'(rate_sel)));
        ticks.gate_tick     = &(div_q | ~low_ones(GATE_SHIFT));
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            div_q <= '0;
        else
            div_q <= div_d;
    end
endmodule

// ==== src/tick_if.sv ====
// Purpose: rate enables from the divider to the flag logic
// Assumes: periodic and gate pulses one clk_sys cycle long; count_tick high every cycle at prescale 00
// Notes:   none
`timescale 1ns/1ps
interface tick_if;
    logic count_tick;
    logic periodic_tick;
    logic gate_tick;

    modport source (output count_tick, output periodic_tick, output gate_tick);
    modport sink   (input count_tick, input periodic_tick, input gate_tick);
endinterface

// ==== src/timer_flags_pulse_accumulator.sv ====
// Purpose: timer flags, masks, prescaler, periodic tick and pulse accumulator
// Assumes: compare values and capture pins come from the surrounding timer
// Notes:   the free-running counter lives here; compare latches do not
`timescale 1ns/1ps

module timer_flags_pulse_accumulator
    import tmr_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [15:0]      reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    input  wire logic             test_mode,
    input  wire logic [3:0]       cap_pin,
    input  wire logic             accum_input_pin,
    input  wire logic [4:0][15:0] cmp_value,
    output logic      [15:0]      free_running_count,
    output logic      [7:0]       irq_req_one,
    output logic      [7:0]       irq_req_two,
    output logic      [3:0]       capture_event
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0]  edge_ctrl_q, edge_ctrl_d;
    logic [7:0]  en_one_q, en_one_d;
    logic [7:0]  flg_one_q, flg_one_d;
    logic [7:0]  en_two_q, en_two_d;
    logic [7:0]  flg_two_q, flg_two_d;
    logic [1:0]  presc_q, presc_d;
    logic        presc_done_q, presc_done_d;
    logic [6:0]  win_q, win_d;
    logic [7:0]  actl_q, actl_d;
    logic [7:0]  acnt_q, acnt_d;
    logic [15:0] count_q, count_d;
    logic [7:0]  rdata_d;
    logic [7:0]  irq_one_d, irq_two_d;

    logic [4:0]  pin_lvl;
    logic [4:0]  pin_rise;
    logic [4:0]  pin_fall;
    logic [4:0]  cmp_hit;
    logic [3:0]  cap_evt;
    logic [7:0]  set_one;
    logic [7:0]  set_two;
    logic        wr_edge, wr_en1, wr_flg1, wr_en2, wr_flg2, wr_actl, wr_acnt;
    logic        presc_ok, counter_rollover_flag, acc_inc, acc_edge, acc_roll;

    tick_if u_ticks ();

    tick_divider #(
        .DIV_W     (16)
    ) u_div (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .presc_sel (presc_q),
        .rate_sel  (actl_q[1:0]),
        .ticks     (u_ticks.source)
    );

    pin_sync #(
        .W       (5)
    ) u_pins (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin_in  ({accum_input_pin, cap_pin}),
        .level   (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    always_comb
    begin
        wr_edge = reg_wr && (reg_addr == OFS_EDGE_CTRL);
        wr_en1  = reg_wr && (reg_addr == OFS_EN_ONE);
        wr_flg1 = reg_wr && (reg_addr == OFS_FLG_ONE);
        wr_en2  = reg_wr && (reg_addr == OFS_EN_TWO);
        wr_flg2 = reg_wr && (reg_addr == OFS_FLG_TWO);
        wr_actl = reg_wr && (reg_addr == OFS_ACC_CTRL);
        wr_acnt = reg_wr && (reg_addr == OFS_ACC_CNT);
    end

    // ----------------------------------------
    // counter and event sources
    // ----------------------------------------
    always_comb
    begin
        count_d = count_q + {15'h0000, u_ticks.count_tick};
        counter_rollover_flag     = u_ticks.count_tick && (count_q == CNT_MAX);
    end

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_cmp
            assign cmp_hit[gi] = u_ticks.count_tick && (count_d == cmp_value[gi]);
        end
        for (gi = 0; gi < 4; gi++)
        begin : g_cap
            assign cap_evt[gi] = (edge_ctrl_q[EDGE_LSB[gi]] & pin_rise[gi])
                               | (edge_ctrl_q[EDGE_LSB[gi] + 1] & pin_fall[gi]);
        end
    endgenerate

    // ----------------------------------------
    // pulse accumulator
    // ----------------------------------------
    always_comb
    begin
        acc_edge = actl_q[ACT_ENABLE]
                 & (actl_q[ACT_EDGE] ? pin_rise[4] : pin_fall[4]);
        if (!actl_q[ACT_ENABLE])
            acc_inc = 1'h0;
        else if (actl_q[ACT_MODE])
            acc_inc = u_ticks.gate_tick && (pin_lvl[4] != actl_q[ACT_EDGE]);
        else
            acc_inc = acc_edge;
        acc_roll = acc_inc && !wr_acnt && (acnt_q == ACC_MAX);
        if (wr_acnt)
            acnt_d = reg_wdata;
        else
            acnt_d = acnt_q + {7'h00, acc_inc};
    end

    // ----------------------------------------
    // flags and masks
    // ----------------------------------------
    always_comb
    begin
        set_one = {cmp_hit[0], cmp_hit[1], cmp_hit[2], cmp_hit[3],
                   1'h0, cap_evt[0], cap_evt[1], cap_evt[2]};
        set_one[ONE_CMP5_BIT] = actl_q[ACT_SEL45] ? cap_evt[3] : cmp_hit[4];
        set_two = REG_RST;
        set_two[TWO_ROLL_BIT]  = counter_rollover_flag;
        set_two[TWO_TICK_BIT]  = u_ticks.periodic_tick;
        set_two[TWO_AROLL_BIT] = acc_roll;
        set_two[TWO_AEDGE_BIT] = acc_edge;
        flg_one_d = (flg_one_q & ~(wr_flg1 ? reg_wdata : REG_RST)) | set_one;
        flg_two_d = ((flg_two_q & ~(wr_flg2 ? reg_wdata : REG_RST)) | set_two) & EN_TWO_MASK;
        edge_ctrl_d = wr_edge ? reg_wdata : edge_ctrl_q;
        en_one_d    = wr_en1 ? reg_wdata : en_one_q;
        en_two_d    = wr_en2 ? (reg_wdata & EN_TWO_MASK) : en_two_q;
        actl_d      = wr_actl ? reg_wdata : actl_q;
        irq_one_d   = flg_one_q & en_one_q;
        irq_two_d   = flg_two_q & en_two_q;
    end

    // ----------------------------------------
    // prescaler write window
    // ----------------------------------------
    always_comb
    begin
        presc_ok     = test_mode || (!presc_done_q && (win_q != PRESC_WIN));
        win_d        = (win_q == PRESC_WIN) ? win_q : win_q + 7'h01;
        presc_d      = presc_q;
        presc_done_d = presc_done_q;
        if (wr_en2 && presc_ok)
        begin
            presc_d      = reg_wdata[1:0];
            presc_done_d = 1'h1;
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb
    begin
        rdata_d = REG_RST;
        if (reg_rd)
        begin
            case (reg_addr)
                OFS_EDGE_CTRL: rdata_d = edge_ctrl_q;
                OFS_EN_ONE:    rdata_d = en_one_q;
                OFS_FLG_ONE:   rdata_d = flg_one_q;
                OFS_EN_TWO:    rdata_d = en_two_q | {6'h00, presc_q};
                OFS_FLG_TWO:   rdata_d = flg_two_q;
                OFS_ACC_CTRL:  rdata_d = actl_q;
                OFS_ACC_CNT:   rdata_d = acnt_q;
                default:       rdata_d = REG_RST;
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            edge_ctrl_q        <= REG_RST;
            en_one_q           <= REG_RST;
            flg_one_q          <= REG_RST;
            en_two_q           <= REG_RST;
            flg_two_q          <= REG_RST;
            presc_q            <= '0;
            presc_done_q       <= '0;
            win_q              <= '0;
            actl_q             <= REG_RST;
            acnt_q             <= REG_RST;
            count_q            <= CNT_RST;
            reg_rdata          <= REG_RST;
            irq_req_one        <= REG_RST;
            irq_req_two        <= REG_RST;
            capture_event      <= '0;
        end
        else
        begin
            edge_ctrl_q        <= edge_ctrl_d;
            en_one_q           <= en_one_d;
            flg_one_q          <= flg_one_d;
            en_two_q           <= en_two_d;
            flg_two_q          <= flg_two_d;
            presc_q            <= presc_d;
            presc_done_q       <= presc_done_d;
            win_q              <= win_d;
            actl_q             <= actl_d;
            acnt_q             <= acnt_d;
            count_q            <= count_d;
            reg_rdata          <= rdata_d;
            irq_req_one        <= irq_one_d;
            irq_req_two        <= irq_two_d;
            capture_event      <= cap_evt;
        end
    end

    assign free_running_count = count_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_cap1_rise;
        (edge_ctrl_q[5:4] == 2'h1) ##0 pin_rise[0];
    endsequence

    sequence s_late_presc_wr;
        !test_mode && (win_q == PRESC_WIN) ##0 wr_en2;
    endsequence

    chk_w1c_clear: assert property (
        (wr_flg1 && (set_one == 8'h00)) |=> ((flg_one_q & $past(reg_wdata)) == 8'h00))
        else $error("flag one not cleared by write of one");

    chk_set_wins: assert property (
        (set_two != 8'h00) |=> ((flg_two_q & $past(set_two)) == $past(set_two)))
        else $error("flag event lost against clear");

    chk_mask_gate: assert property (
        (en_one_q == 8'h00) ##1 (en_one_q == 8'h00) |-> (irq_req_one == 8'h00))
        else $error("masked source requested interrupt");

    chk_rollover_flag: assert property (
        (count_q == CNT_MAX && u_ticks.count_tick)
        |=> (count_q == CNT_RST) && flg_two_q[TWO_ROLL_BIT])
        else $error("counter rollover did not set flag");

    chk_presc_lock: assert property (
        s_late_presc_wr |=> $stable(presc_q))
        else $error("prescaler changed after write window");

    chk_accum_roll: assert property (
        (acc_inc && !wr_acnt && acnt_q == ACC_MAX)
        |=> (acnt_q == 8'h00) && flg_two_q[TWO_AROLL_BIT])
        else $error("accumulator rollover wrong");

    chk_gate_inhibit: assert property (
        (actl_q[ACT_ENABLE] && actl_q[ACT_MODE] && !wr_acnt
         && pin_lvl[4] == actl_q[ACT_EDGE]) |=> $stable(acnt_q))
        else $error("gated accumulator counted while inhibited");

    chk_periodic_flag: assert property (
        u_ticks.periodic_tick |=> flg_two_q[TWO_TICK_BIT])
        else $error("periodic tick did not set flag");

    chk_capture_rise: assert property (
        s_cap1_rise |=> flg_one_q[2] ##1 capture_event[0] == 1'h0)
        else $error("rising capture on channel one missed");

    chk_presc_rate: assert property (
        (presc_q == 2'h3 && presc_done_q && !test_mode && u_ticks.count_tick)
        |=> !u_ticks.count_tick [*8])
        else $error("divide by sixteen ticked early");

    chk_event_count: assert property (
        (actl_q[ACT_ENABLE] && !actl_q[ACT_MODE] && !actl_q[ACT_EDGE]
         && pin_fall[4] && !wr_acnt) |=> (acnt_q == $past(acnt_q) + 8'h01))
        else $error("falling edge not counted");

    chk_compare_flag: assert property (
        cmp_hit[0] |=> flg_one_q[7])
        else $error("compare match did not set flag");

    chk_cmp5_select: assert property (
        (!actl_q[ACT_SEL45] && cmp_hit[4]) |=> flg_one_q[ONE_CMP5_BIT])
        else $error("compare five did not set shared flag");

    chk_accum_edge: assert property (
        acc_edge |=> flg_two_q[TWO_AEDGE_BIT])
        else $error("accumulator edge did not set flag");

    chk_count_hold: assert property (
        !u_ticks.count_tick |=> $stable(count_q))
        else $error("counter moved without prescale tick");
endmodule

// ==== src/tmr_pkg.sv ====
// Purpose: constants shared by the timer flag and pulse accumulator block
// Assumes: byte-wide register port, bus clock equal to clk_sys
// Notes:   offsets are the byte addresses seen on reg_addr
package tmr_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [15:0] OFS_EDGE_CTRL = 16'h1021;
    localparam logic [15:0] OFS_EN_ONE    = 16'h1022;
    localparam logic [15:0] OFS_FLG_ONE   = 16'h1023;
    localparam logic [15:0] OFS_EN_TWO    = 16'h1024;
    localparam logic [15:0] OFS_FLG_TWO   = 16'h1025;
    localparam logic [15:0] OFS_ACC_CTRL  = 16'h1026;
    localparam logic [15:0] OFS_ACC_CNT   = 16'h1027;

    // ----------------------------------------
    // reset values and limits
    // ----------------------------------------
    localparam logic [7:0]  REG_RST   = 8'h00;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [7:0]  ACC_MAX   = 8'hFF;
    localparam logic [6:0]  PRESC_WIN = 7'h40;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int          ONE_CMP5_BIT  = 3;
    localparam int          TWO_ROLL_BIT  = 7;
    localparam int          TWO_TICK_BIT  = 6;
    localparam int          TWO_AROLL_BIT = 5;
    localparam int          TWO_AEDGE_BIT = 4;
    localparam logic [7:0]  EN_TWO_MASK   = 8'hF0;
    localparam int          ACT_ENABLE    = 6;
    localparam int          ACT_MODE      = 5;
    localparam int          ACT_EDGE      = 4;
    localparam int          ACT_SEL45     = 2;
    // edge field lsb per capture channel 1, 2, 3, 4
    localparam int          EDGE_LSB [4]  = '{4, 2, 0, 6};

    // ----------------------------------------
    // divider shifts
    // ----------------------------------------
    localparam int          PRESC_SHIFT [4] = '{0, 2, 3, 4};
    localparam int          RATE_SHIFT_BASE = 13;
    localparam int          GATE_SHIFT      = 6;

endpackage
